// ==== hdl/isr_pkg.sv ====
/*
 Constants, register indices, bit positions and the command carrier
 for the instrument status reporting block.
 Assumes one 50 MHz core clock and a synchronous active-high reset.
*/
// Contract
// - Operation condition: calibration bit 0, current modes at bits 10, 11, 12.
// - Questionable: overvoltage 0, overcurrent 1, overtemperature 4, output-2 overcurrent 12.
// - Questionable: keypress 3, sense 5, unreg2 8, inhibit 9, unreg 10, overload 14.
// - Standard event: complete 0, query 2, device 3, execution 4, command 5, power-on 7.
// - Status byte: questionable 3, message 4, standard 5, master/request 6, operation 7.
// - Status byte bit 7 is OR of enabled operation event bits.
// - Status byte bit 3 is OR of enabled questionable event bits.
// - Condition registers follow live signals and ignore writes.
// - Rise filter lets low-to-high condition changes set event bits.
// - Fall filter lets high-to-low condition changes set event bits.
// - Event bits stay set until read; a read returns then clears them.
// - Enable mask picks which event bits feed the group summary.
// - Standard event latch is read-only, clears on read, masked into its summary.
// - Controller writes standard event mask; querying standard events returns and clears.
// - Power-on-clear on clears standard event mask at power-up, else retained.
// - Power-on bit 7 of standard events sets at every power-up.
// - Master summary is unlatched OR of enabled status bits; status read clears nothing.
// - Request latches into bit 6, drives request line; poll returns and clears it.
// - Message-available bit 4 is set while the output queue is not empty.
package isr_pkg;
   localparam int GRP_W = 16;
   localparam int STD_W = 8;
   // Operation condition bits
   localparam int OP_CAL = 0;
   localparam int OP_TRIG = 5;
   localparam int OP_CV = 8;
   localparam int OP_CV2 = 9;
   localparam int OP_CCP = 10;
   localparam int OP_CCN = 11;
   localparam int OP_CC2 = 12;
   // Questionable condition bits
   localparam int QS_OV = 0;
   localparam int QS_OC = 1;
   localparam int QS_KEY = 3;
   localparam int QS_OT = 4;
   localparam int QS_SENSE = 5;
   localparam int QS_SECOND_OUTPUT_UNREGULATED = 8;
   localparam int QS_INH = 9;
   localparam int QS_UNR = 10;
   localparam int QS_OC2 = 12;
   localparam int QS_OVLD = 14;
   // Standard event bits
   localparam int SE_OPC = 0;
   localparam int SE_QRY = 2;
   localparam int SE_DEV = 3;
   localparam int SE_EXE = 4;
   localparam int SE_CMD = 5;
   localparam int SE_PON = 7;
   // Status byte bits
   localparam int SB_QUESTIONABLE_SUMMARY = 3;
   localparam int SB_MAV = 4;
   localparam int SB_ESB = 5;
   localparam int SB_MSS = 6;
   localparam int SB_OPERATION_SUMMARY = 7;
   // Register indices on the command port
   localparam logic [3:0] IX_OP_COND = 4'h0;
   localparam logic [3:0] IX_OP_RISE = 4'h1;
   localparam logic [3:0] IX_OP_FALL = 4'h2;
   localparam logic [3:0] IX_OP_EVT = 4'h3;
   localparam logic [3:0] IX_OP_MASK = 4'h4;
   localparam logic [3:0] IX_QS_COND = 4'h5;
   localparam logic [3:0] IX_QS_RISE = 4'h6;
   localparam logic [3:0] IX_QS_FALL = 4'h7;
   localparam logic [3:0] IX_QS_EVT = 4'h8;
   localparam logic [3:0] IX_QS_MASK = 4'h9;
   localparam logic [3:0] IX_SE_EVT = 4'hA;
   localparam logic [3:0] IX_SE_MASK = 4'hB;
   localparam logic [3:0] IX_STB = 4'hC;
   localparam logic [3:0] IX_SRQ_MASK = 4'hD;
   localparam logic [3:0] IX_POLL = 4'hE;
   // Reset values
   localparam logic [15:0] RISE_RST = 16'h7FFF;
   localparam logic [15:0] FALL_RST = 16'h0000;
   localparam logic [15:0] MASK_RST = 16'h0000;
   // One register access from the command interpreter
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] sel;
      logic [15:0] data;
   } isr_cmd_t;
endpackage

// ==== hdl/isr_status_group.sv ====
/*
 One status group: condition, transition detect, event latch, summary.
 Assumes the masks are held by the parent and clrEvent is a one-cycle read strobe.
*/
`timescale 1ns/1ns
module isr_status_group #(
   parameter int W = 16
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] cond,
   input wire logic [W-1:0] riseMask,
   input wire logic [W-1:0] fallMask,
   input wire logic [W-1:0] enMask,
   input wire logic clrEvent,
   output logic [W-1:0] condQ,
   output logic [W-1:0] eventQ,
   output logic summary
);
   logic [W-1:0] cond_q;
   logic [W-1:0] prev_q;
   logic [W-1:0] event_q;
   logic [W-1:0] event_d;
   logic [W-1:0] setBits;
   logic [W-1:0] riseHit;
   logic [W-1:0] fallHit;

   // Edge pulses last one cycle, filtered per bit
   assign riseHit = cond_q & ~prev_q & riseMask;
   assign fallHit = ~cond_q & prev_q & fallMask;
   assign setBits = riseHit | fallHit;
   // Set wins over the clearing read so no event slips between read and clear
   assign event_d = (event_q & ~{W{clrEvent}}) | setBits;
   assign summary = |(event_q & enMask);
   assign condQ = cond_q;
   assign eventQ = event_q;

   // Condition follows the live inputs; there is no write path to it
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cond_q <= '0;
         prev_q <= '0;
         event_q <= '0;
      end else begin
         cond_q <= cond;
         prev_q <= cond_q;
         event_q <= event_d;
      end
   end

   // Each filtered edge must land in its own event bit, not just in some bit
   a_rise_sets_event: assert property (@(posedge core_clk) disable iff (sys_rst)
      (|riseHit) |=> ((event_q & $past(riseHit)) == $past(riseHit)))
      else $error("filtered rise did not set its event bit");
   a_fall_sets_event: assert property (@(posedge core_clk) disable iff (sys_rst)
      (|fallHit) |=> ((event_q & $past(fallHit)) == $past(fallHit)))
      else $error("filtered fall did not set its event bit");
   a_set_beats_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
      (clrEvent && |setBits) |=> ((event_q & $past(setBits)) == $past(setBits)))
      else $error("event lost during clearing read");
endmodule // isr_status_group

// ==== hdl/isr_service_request.sv ====
/*
 Master summary and latched request for the status byte.
 Assumes statusBits carries every summary bit except bit 6.
*/
`timescale 1ns/1ns
module isr_service_request (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] statusBits,
   input wire logic [7:0] srqMask,
   input wire logic pollClear,
   output logic mss,
   output logic rqsQ
);
   logic mssPrev_q;
   logic rqs_q;
   logic rqs_d;
   logic [7:0] maskNoMss;

   // Bit 6 of the mask has no source and must not feed back on itself
   assign maskNoMss = srqMask & ~(8'h01 << isr_pkg::SB_MSS);
   assign mss = |(statusBits & maskNoMss);
   // A new reason for service latches a request; a poll clears it, new request wins
   assign rqs_d = (mss & ~mssPrev_q) | (rqs_q & ~pollClear);
   assign rqsQ = rqs_q;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mssPrev_q <= 1'b0;
         rqs_q <= 1'b0;
      end else begin
         mssPrev_q <= mss;
         rqs_q <= rqs_d;
      end
   end

   a_request_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
      (mss && !mssPrev_q) |=> rqs_q)
      else $error("request not latched on new service reason");
endmodule // isr_service_request

// ==== hdl/isr_status_top.sv ====
/*
 Status reporting core: operation, questionable and standard event groups,
 status byte, request mask and the command read/write port.
 Assumes the command interpreter issues at most one access per cycle and
 that monitored signals and event pulses are synchronous to core_clk.
*/
`timescale 1ns/1ns
module isr_status_top (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic powerOnClear,
   input wire isr_pkg::isr_cmd_t cmd,
   input wire logic calibrationBusy,
   input wire logic awaitingTriggerFlag,
   input wire logic voltageRegulationFlag,
   input wire logic secondOutputVoltageRegulation,
   input wire logic positiveCurrentRegulation,
   input wire logic negativeCurrentRegulation,
   input wire logic secondOutputCurrentRegulation,
   input wire logic overvoltageTrip,
   input wire logic overcurrentTrip,
   input wire logic localKeypressFlag,
   input wire logic overtemperatureTrip,
   input wire logic openSenseLead,
   input wire logic secondOutputUnregulated,
   input wire logic externalInhibitActive,
   input wire logic mainOutputUnregulated,
   input wire logic secondOutputOvercurrentTrip,
   input wire logic lowRangeCurrentOverload,
   input wire logic opComplete,
   input wire logic queryError,
   input wire logic deviceError,
   input wire logic executionError,
   input wire logic commandError,
   input wire logic queueNotEmpty,
   output logic [15:0] rdData,
   output logic rdValid,
   output logic serviceRequest,
   output logic [7:0] statusByte
);
   logic [15:0] opRise_q;
   logic [15:0] opFall_q;
   logic [15:0] opMask_q;
   logic [15:0] qsRise_q;
   logic [15:0] qsFall_q;
   logic [15:0] qsMask_q;
   logic [7:0] seEvent_q;
   logic [7:0] seEvent_d;
   logic [7:0] seMask_q;
   logic [7:0] srqMask_q;
   logic [15:0] rdData_q;
   logic rdValid_q;
   logic srqLine_q;
   logic [7:0] statusByte_q;
   logic [15:0] opCond;
   logic [15:0] qsCond;
   logic [7:0] seSet;
   logic [15:0] opCondQ;
   logic [15:0] opEvent;
   logic [15:0] qsCondQ;
   logic [15:0] qsEvent;
   logic opSummary;
   logic qsSummary;
   logic seSummary;
   logic mss;
   logic rqs;
   logic [7:0] stbRaw;
   logic [7:0] stbRead;
   logic [7:0] stbPoll;
   logic [15:0] rdMux;
   logic wrOpRise;
   logic wrOpFall;
   logic wrOpMask;
   logic wrQsRise;
   logic wrQsFall;
   logic wrQsMask;
   logic wrSeMask;
   logic wrSrqMask;
   logic rdOpEvt;
   logic rdQsEvt;
   logic rdSeEvt;
   logic rdPoll;

   // Operation condition word, undefined bits tied low
   assign opCond = (16'(calibrationBusy) << isr_pkg::OP_CAL)
                 | (16'(awaitingTriggerFlag) << isr_pkg::OP_TRIG)
                 | (16'(voltageRegulationFlag) << isr_pkg::OP_CV)
                 | (16'(secondOutputVoltageRegulation) << isr_pkg::OP_CV2)
                 | (16'(positiveCurrentRegulation) << isr_pkg::OP_CCP)
                 | (16'(negativeCurrentRegulation) << isr_pkg::OP_CCN)
                 | (16'(secondOutputCurrentRegulation) << isr_pkg::OP_CC2);
   // Questionable condition word
   assign qsCond = (16'(overvoltageTrip) << isr_pkg::QS_OV)
                 | (16'(overcurrentTrip) << isr_pkg::QS_OC)
                 | (16'(localKeypressFlag) << isr_pkg::QS_KEY)
                 | (16'(overtemperatureTrip) << isr_pkg::QS_OT)
                 | (16'(openSenseLead) << isr_pkg::QS_SENSE)
                 | (16'(secondOutputUnregulated) << isr_pkg::QS_SECOND_OUTPUT_UNREGULATED)
                 | (16'(externalInhibitActive) << isr_pkg::QS_INH)
                 | (16'(mainOutputUnregulated) << isr_pkg::QS_UNR)
                 | (16'(secondOutputOvercurrentTrip) << isr_pkg::QS_OC2)
                 | (16'(lowRangeCurrentOverload) << isr_pkg::QS_OVLD);
   // Standard event pulses, power-on is loaded by reset instead
   assign seSet = (8'(opComplete) << isr_pkg::SE_OPC)
                | (8'(queryError) << isr_pkg::SE_QRY)
                | (8'(deviceError) << isr_pkg::SE_DEV)
                | (8'(executionError) << isr_pkg::SE_EXE)
                | (8'(commandError) << isr_pkg::SE_CMD);

   // Write and clearing-read decode
   assign wrOpRise = cmd.wr && (cmd.sel == isr_pkg::IX_OP_RISE);
   assign wrOpFall = cmd.wr && (cmd.sel == isr_pkg::IX_OP_FALL);
   assign wrOpMask = cmd.wr && (cmd.sel == isr_pkg::IX_OP_MASK);
   assign wrQsRise = cmd.wr && (cmd.sel == isr_pkg::IX_QS_RISE);
   assign wrQsFall = cmd.wr && (cmd.sel == isr_pkg::IX_QS_FALL);
   assign wrQsMask = cmd.wr && (cmd.sel == isr_pkg::IX_QS_MASK);
   assign wrSeMask = cmd.wr && (cmd.sel == isr_pkg::IX_SE_MASK);
   assign wrSrqMask = cmd.wr && (cmd.sel == isr_pkg::IX_SRQ_MASK);
   assign rdOpEvt = cmd.rd && (cmd.sel == isr_pkg::IX_OP_EVT);
   assign rdQsEvt = cmd.rd && (cmd.sel == isr_pkg::IX_QS_EVT);
   assign rdSeEvt = cmd.rd && (cmd.sel == isr_pkg::IX_SE_EVT);
   assign rdPoll = cmd.rd && (cmd.sel == isr_pkg::IX_POLL);

   isr_status_group #(.W(isr_pkg::GRP_W)) u_operation_summary (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .cond(opCond),
      .riseMask(opRise_q),
      .fallMask(opFall_q),
      .enMask(opMask_q),
      .clrEvent(rdOpEvt),
      .condQ(opCondQ),
      .eventQ(opEvent),
      .summary(opSummary)
   );

   isr_status_group #(.W(isr_pkg::GRP_W)) u_questionable_summary (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .cond(qsCond),
      .riseMask(qsRise_q),
      .fallMask(qsFall_q),
      .enMask(qsMask_q),
      .clrEvent(rdQsEvt),
      .condQ(qsCondQ),
      .eventQ(qsEvent),
      .summary(qsSummary)
   );

   // Standard event latch: clearing read, but a same-cycle event survives
   assign seEvent_d = (seEvent_q & ~{8{rdSeEvt}}) | seSet;
   assign seSummary = |(seEvent_q & seMask_q);

   // Status byte without bit 6
   assign stbRaw = (8'(qsSummary) << isr_pkg::SB_QUESTIONABLE_SUMMARY)
                 | (8'(queueNotEmpty) << isr_pkg::SB_MAV)
                 | (8'(seSummary) << isr_pkg::SB_ESB)
                 | (8'(opSummary) << isr_pkg::SB_OPERATION_SUMMARY);
   // Status query shows the live master summary; poll shows the latched request
   assign stbRead = stbRaw | (8'(mss) << isr_pkg::SB_MSS);
   assign stbPoll = stbRaw | (8'(rqs) << isr_pkg::SB_MSS);

   isr_service_request u_srq (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .statusBits(stbRaw),
      .srqMask(srqMask_q),
      .pollClear(rdPoll),
      .mss(mss),
      .rqsQ(rqs)
   );

   // Read selection; unmapped indices read zero
   always_comb begin
      case (cmd.sel)
         isr_pkg::IX_OP_COND: rdMux = opCondQ;
         isr_pkg::IX_OP_RISE: rdMux = opRise_q;
         isr_pkg::IX_OP_FALL: rdMux = opFall_q;
         isr_pkg::IX_OP_EVT: rdMux = opEvent;
         isr_pkg::IX_OP_MASK: rdMux = opMask_q;
         isr_pkg::IX_QS_COND: rdMux = qsCondQ;
         isr_pkg::IX_QS_RISE: rdMux = qsRise_q;
         isr_pkg::IX_QS_FALL: rdMux = qsFall_q;
         isr_pkg::IX_QS_EVT: rdMux = qsEvent;
         isr_pkg::IX_QS_MASK: rdMux = qsMask_q;
         isr_pkg::IX_SE_EVT: rdMux = {8'h00, seEvent_q};
         isr_pkg::IX_SE_MASK: rdMux = {8'h00, seMask_q};
         isr_pkg::IX_STB: rdMux = {8'h00, stbRead};
         isr_pkg::IX_SRQ_MASK: rdMux = {8'h00, srqMask_q};
         isr_pkg::IX_POLL: rdMux = {8'h00, stbPoll};
         default: rdMux = 16'h0000;
      endcase
   end

   // Filter and mask registers; condition indices have no write decode
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         opRise_q <= isr_pkg::RISE_RST;
         opFall_q <= isr_pkg::FALL_RST;
         opMask_q <= isr_pkg::MASK_RST;
         qsRise_q <= isr_pkg::RISE_RST;
         qsFall_q <= isr_pkg::FALL_RST;
         qsMask_q <= isr_pkg::MASK_RST;
      end else begin
         if (wrOpRise) opRise_q <= cmd.data;
         if (wrOpFall) opFall_q <= cmd.data;
         if (wrOpMask) opMask_q <= cmd.data;
         if (wrQsRise) qsRise_q <= cmd.data;
         if (wrQsFall) qsFall_q <= cmd.data;
         if (wrQsMask) qsMask_q <= cmd.data;
      end
   end

   // Masks survive power-up unless power-on clearing is selected, so a
   // request after an unexpected power loss can still be raised
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         if (powerOnClear) begin
            seMask_q <= 8'h00;
            srqMask_q <= 8'h00;
         end
      end else begin
         if (wrSeMask) seMask_q <= cmd.data[7:0];
         if (wrSrqMask) srqMask_q <= cmd.data[7:0];
      end
   end

   // Standard events; every power-up records the power-on bit
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         seEvent_q <= 8'h01 << isr_pkg::SE_PON;
      end else begin
         seEvent_q <= seEvent_d;
      end
   end

   // Registered outputs
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rdData_q <= 16'h0000;
         rdValid_q <= 1'b0;
         srqLine_q <= 1'b0;
         statusByte_q <= 8'h00;
      end else begin
         rdData_q <= cmd.rd ? rdMux : rdData_q;
         rdValid_q <= cmd.rd;
         srqLine_q <= rqs;
         statusByte_q <= stbRead;
      end
   end

   assign rdData = rdData_q;
   assign rdValid = rdValid_q;
   assign serviceRequest = srqLine_q;
   assign statusByte = statusByte_q;

   // Checker copy of the previous condition word; a bit that is set again during
   // the clearing read is legal, so the check needs the expected new pulses
   logic [15:0] opCondPrev_q;
   logic [15:0] opSetExp;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         opCondPrev_q <= 16'h0000;
      end else begin
         opCondPrev_q <= opCondQ;
      end
   end
   // Transitions the operation filters let through in this cycle
   assign opSetExp = (opCondQ & ~opCondPrev_q & opRise_q)
                   | (~opCondQ & opCondPrev_q & opFall_q);

   sequence s_read_op_event;
      rdOpEvt && opEvent != 16'h0000;
   endsequence
   sequence s_returned_then_clear;
      rdValid_q && rdData_q == $past(opEvent) ##0 opEvent == $past(opSetExp);
   endsequence

   a_operation_summary_summary_bit: assert property (@(posedge core_clk) disable iff (sys_rst)
      ##1 statusByte_q[isr_pkg::SB_OPERATION_SUMMARY] == $past(|(opEvent & opMask_q)))
      else $error("operation summary bit wrong");
   a_questionable_summary_summary_bit: assert property (@(posedge core_clk) disable iff (sys_rst)
      ##1 statusByte_q[isr_pkg::SB_QUESTIONABLE_SUMMARY] == $past(|(qsEvent & qsMask_q)))
      else $error("questionable summary bit wrong");
   a_event_read_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
      s_read_op_event |=> s_returned_then_clear)
      else $error("event read did not return and clear");
   a_std_read_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
      (rdSeEvt && seSet == 8'h00) |=> seEvent_q == 8'h00 && rdData_q[7:0] == $past(seEvent_q))
      else $error("standard event read did not clear");
   a_power_on_bit: assert property (@(posedge core_clk)
      $fell(sys_rst) |-> seEvent_q[isr_pkg::SE_PON])
      else $error("power-on bit missing after reset");
   a_mask_power_clear: assert property (@(posedge core_clk)
      (sys_rst && powerOnClear) |=> seMask_q == 8'h00)
      else $error("standard event mask not cleared at power-up");
   a_cond_follows_live: assert property (@(posedge core_clk) disable iff (sys_rst)
      ##1 opCondQ == $past(opCond) && qsCondQ == $past(qsCond))
      else $error("condition register not following inputs");
   a_message_bit: assert property (@(posedge core_clk) disable iff (sys_rst)
      ##1 statusByte_q[isr_pkg::SB_MAV] == $past(queueNotEmpty))
      else $error("message available bit wrong");
   a_poll_clears_rqs: assert property (@(posedge core_clk) disable iff (sys_rst)
      (rdPoll && rqs && $stable(mss)) |=> !rqs ##1 !serviceRequest)
      else $error("poll did not clear request");
endmodule // isr_status_top

// ==== bench/isr_ctrl_model.sv ====
/*
 Remote controller model: issues register writes and reads on the command port.
 Assumes one access per strobe and an answer pulse on rdValid within a few cycles.
*/
`timescale 1ns/1ns
module isr_ctrl_model (
   input wire logic core_clk,
   output isr_pkg::isr_cmd_t cmd,
   input wire logic rdValid,
   input wire logic [15:0] rdData
);
   initial cmd = '0;
   // One write strobe for a single cycle, then idle
   task automatic wr(input logic [3:0] s, input logic [15:0] v);
      @(posedge core_clk);
      cmd <= '{wr: 1'b1, rd: 1'b0, sel: s, data: v};
      @(posedge core_clk);
      cmd <= '0;
   endtask
   // Read strobe; a missing answer returns unknowns so no compare can pass
   task automatic rd(input logic [3:0] s, output logic [15:0] v);
      int n;
      @(posedge core_clk);
      cmd <= '{wr: 1'b0, rd: 1'b1, sel: s, data: 16'h0000};
      @(posedge core_clk);
      cmd <= '0;
      n = 0;
      #1;
      while (rdValid !== 1'b1 && n < 4) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      v = (rdValid === 1'b1) ? rdData : 16'hXXXX;
   endtask
endmodule // isr_ctrl_model

// ==== bench/tb_instrument_status_reporting.sv ====
/*
 Self-checking bench for the status reporting core.
 Assumes isr_ctrl_model drives the command port; all other inputs come from here.
*/
`timescale 1ns/1ns
module tb_instrument_status_reporting;
   logic core_clk, sys_rst, powerOnClear, queueNotEmpty, rdValid, serviceRequest;
   logic [15:0] opIn, qsIn, rdData, d;
   logic [5:0] seEv;
   logic [7:0] statusByte;
   isr_pkg::isr_cmd_t cmd;
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;

   // Free-running 50 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   isr_ctrl_model M (.core_clk(core_clk), .cmd(cmd), .rdValid(rdValid), .rdData(rdData));

   isr_status_top DUT (
      .core_clk(core_clk), .sys_rst(sys_rst), .powerOnClear(powerOnClear), .cmd(cmd),
      .calibrationBusy(opIn[0]), .awaitingTriggerFlag(opIn[5]),
      .voltageRegulationFlag(opIn[8]), .secondOutputVoltageRegulation(opIn[9]),
      .positiveCurrentRegulation(opIn[10]), .negativeCurrentRegulation(opIn[11]),
      .secondOutputCurrentRegulation(opIn[12]), .overvoltageTrip(qsIn[0]),
      .overcurrentTrip(qsIn[1]), .localKeypressFlag(qsIn[3]),
      .overtemperatureTrip(qsIn[4]), .openSenseLead(qsIn[5]),
      .secondOutputUnregulated(qsIn[8]), .externalInhibitActive(qsIn[9]),
      .mainOutputUnregulated(qsIn[10]), .secondOutputOvercurrentTrip(qsIn[12]),
      .lowRangeCurrentOverload(qsIn[14]), .opComplete(seEv[0]), .queryError(seEv[2]),
      .deviceError(seEv[3]), .executionError(seEv[4]), .commandError(seEv[5]),
      .queueNotEmpty(queueNotEmpty), .rdData(rdData), .rdValid(rdValid),
      .serviceRequest(serviceRequest), .statusByte(statusByte)
   );

   task test_done;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Hang guard: the whole sequence needs well under 1000 cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         test_done;
      end
   end

   task chk(input string what, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task rdc(input logic [3:0] s, input string what, input logic [15:0] e);
      M.rd(s, d);
      chk(what, e, d);
   endtask
   // Power-up cycle; the setting is sampled only while reset is high
   task reboot(input logic poc);
      @(posedge core_clk);
      sys_rst <= 1'b1;
      powerOnClear <= poc;
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
   endtask

   // Main sequence
   initial begin
      sys_rst = 1'b1;
      powerOnClear = 1'b1;
      queueNotEmpty = 1'b0;
      opIn = 16'h0000;
      qsIn = 16'h0000;
      seEv = 6'h00;
      reboot(1'b1);
      rdc(isr_pkg::IX_SE_EVT, "powerOn", 16'h0080);
      rdc(isr_pkg::IX_SE_EVT, "stdCleared", 16'h0000);
      rdc(isr_pkg::IX_OP_RISE, "riseReset", 16'h7FFF);
      rdc(isr_pkg::IX_QS_FALL, "fallReset", 16'h0000);
      rdc(4'hF, "unmapped", 16'h0000);
      @(posedge core_clk);
      opIn <= 16'hFFFF;
      qsIn <= 16'hFFFF;
      tick(4);
      M.wr(isr_pkg::IX_OP_COND, 16'h0000);
      rdc(isr_pkg::IX_OP_COND, "opCond", 16'h1F21);
      rdc(isr_pkg::IX_QS_COND, "qsCond", 16'h573B);
      M.wr(isr_pkg::IX_QS_MASK, 16'h0010);
      tick(4);
      chk("qsSummary", 16'h0008, {8'h00, statusByte});
      rdc(isr_pkg::IX_QS_EVT, "qsEvent", 16'h573B);
      tick(4);
      chk("qsSummaryOff", 16'h0000, {8'h00, statusByte});
      rdc(isr_pkg::IX_OP_EVT, "opEvent", 16'h1F21);
      M.wr(isr_pkg::IX_OP_RISE, 16'h0000);
      M.wr(isr_pkg::IX_OP_FALL, 16'h0400);
      M.wr(isr_pkg::IX_OP_MASK, 16'h0400);
      @(posedge core_clk);
      opIn <= 16'hFBFF;
      tick(5);
      chk("opSummary", 16'h0080, {8'h00, statusByte});
      M.wr(isr_pkg::IX_SRQ_MASK, 16'h0088);
      tick(5);
      chk("master", 16'h00C0, {8'h00, statusByte});
      chk("srqLine", 16'h0001, {15'h0000, serviceRequest});
      rdc(isr_pkg::IX_STB, "stbRead", 16'h00C0);
      rdc(isr_pkg::IX_STB, "stbAgain", 16'h00C0);
      rdc(isr_pkg::IX_POLL, "poll", 16'h00C0);
      tick(3);
      chk("srqCleared", 16'h0000, {15'h0000, serviceRequest});
      rdc(isr_pkg::IX_OP_EVT, "opFall", 16'h0400);
      @(posedge core_clk);
      queueNotEmpty <= 1'b1;
      tick(4);
      chk("msgAvail", 16'h0010, {8'h00, statusByte});
      @(posedge core_clk);
      queueNotEmpty <= 1'b0;
      seEv <= 6'h3D;
      @(posedge core_clk);
      seEv <= 6'h00;
      rdc(isr_pkg::IX_SE_EVT, "stdBits", 16'h003D);
      // Event pulse lands on the very edge that takes the clearing read
      fork
         M.rd(isr_pkg::IX_SE_EVT, d);
         begin
            @(posedge core_clk);
            seEv <= 6'h01;
            @(posedge core_clk);
            seEv <= 6'h00;
         end
      join
      chk("stdReadClr", 16'h0000, d);
      rdc(isr_pkg::IX_SE_EVT, "stdKept", 16'h0001);
      M.wr(isr_pkg::IX_SE_MASK, 16'h0080);
      M.wr(isr_pkg::IX_SRQ_MASK, 16'h0020);
      rdc(isr_pkg::IX_SE_MASK, "stdMask", 16'h0080);
      M.wr(isr_pkg::IX_QS_FALL, 16'h0013);
      @(posedge core_clk);
      opIn <= 16'h0000;
      qsIn <= 16'h0000;
      tick(4);
      chk("qsFallSummary", 16'h0008, {8'h00, statusByte});
      rdc(isr_pkg::IX_QS_EVT, "qsFall", 16'h0013);
      reboot(1'b0);
      tick(5);
      chk("ponRequest", 16'h0060, {8'h00, statusByte});
      chk("ponLine", 16'h0001, {15'h0000, serviceRequest});
      rdc(isr_pkg::IX_SRQ_MASK, "srqKept", 16'h0020);
      reboot(1'b1);
      rdc(isr_pkg::IX_SE_MASK, "stdMaskClr", 16'h0000);
      test_done;
   end
endmodule // tb_instrument_status_reporting
